// *** verilog/ulsi_status_irq.sv ***
// Notes on behaviour
// - Ready flag set on arrival, cleared by read
// - Overrun flag on lost character, LINE_STATUS read clears
// - Parity error flag, cleared by LINE_STATUS read
// - Framing error on zero stop bit
// - Break flag after input low past character
// - FIFO errors shown when character reaches head
// - Break loads one zero, then waits mark/start
// - Error bits 1-4 raise line status interrupt
// - Holding empty set on shift load, write clears
// - FIFO mode: holding empty follows FIFO empty
// - Transmitter empty needs holding and shifter empty
// - Bit 7 flags any FIFO error entry
// - Five priority levels: line, data, timeout, holding, modem
// - Identification read freezes highest pending source unless holding empty
// - Identification bit 0 low when pending
// - Fixed four-bit source codes in identification
// - Timeout after four idle character times
// - Bit 3 marks timeout, FIFO mode only
// - Bits 4-5 zero, 6-7 follow FIFO enable
// - Each source cleared by its own service
// - Enable bits gate each interrupt source
// - Interrupt output high while enabled source active
`timescale 1ns/1ps
`default_nettype none
module ulsi_status_irq (
    input  wire logic       CLK_I,
    input  wire logic       RST_B_I,
    input  wire logic       CS_I,
    input  wire logic [2:0] ADDR_I,
    input  wire logic       RD_I,
    input  wire logic       WR_I,
    input  wire logic [7:0] DATA_I,
    output logic      [7:0] DATA_O,
    output logic            DATA_OE_B_O,
    input  wire logic       DLAB_I,
    input  wire logic       FIFO_EN_I,
    input  wire logic [1:0] RX_TRIG_I,
    input  wire logic [3:0] IRQ_EN_I,
    input  wire logic       MODEM_DELTA_I,
    input  wire logic       SERIAL_IN_I,
    input  wire logic       CHAR_TICK_I,
    input  wire logic       RX_CHAR_VALID_I,
    input  wire logic [7:0] RX_DATA_I,
    input  wire logic       RX_PE_I,
    input  wire logic       RX_FE_I,
    input  wire logic       RX_START_I,
    input  wire logic       TX_TO_SHIFT_I,
    input  wire logic       TX_FIFO_EMPTY_I,
    input  wire logic       TX_SHIFT_EMPTY_I,
    output logic            INTR_O
);
    typedef struct packed {
        logic       sin_m;
        logic       sin_s;
        logic [1:0] low_ticks;
        logic       brk_hold;
        logic       mark_seen;
        logic       dr;
        logic       oe;
        logic       pe;
        logic       fe;
        logic       bi;
        logic       fifo_err;
        logic       tx_hold_empty_flag;
        logic       tx_hold_empty_flag_irq;
        logic       tmo;
        logic [2:0] tmo_cnt;
        logic       head_fresh;
        logic       fifo_en;
        logic       frz_v;
        logic [3:0] frz_code;
        logic [7:0] rdata;
        logic       oe_b;
        logic       intr;
    } ulsi_state_t;

    ulsi_state_t                      st_q;
    ulsi_state_t                      st_d;
    logic                             rd_acc;
    logic                             wr_acc;
    logic                             rd_rbr;
    logic                             rd_iir;
    logic                             rd_lsr;
    logic                             wr_thr;
    logic                             wr_lsr;
    logic                             brk_evt;
    logic                             push;
    logic                             pop;
    logic                             overrun;
    logic                             fresh;
    logic                             clr;
    logic [ulsi_pkg::ENTRY_W-1:0]     wdata;
    logic [ulsi_pkg::ENTRY_W-1:0]     head;
    logic [ulsi_pkg::CNT_W-1:0]       cnt;
    logic                             full;
    logic                             err_any;
    logic                             data_lvl;
    logic                             line_p;
    logic                             data_p;
    logic                             tmo_p;
    logic                             tx_hold_empty_flag_p;
    logic                             modem_p;
    logic                             frz_live;
    logic [3:0]                       cur_code;
    logic [3:0]                       rep_code;
    logic                             tx_all_empty_flag;
    logic [7:0]                       lsr_byte;
    logic [7:0]                       iir_byte;

    assign rd_acc = CS_I && RD_I;
    assign wr_acc = CS_I && WR_I;
    assign rd_rbr = rd_acc && !DLAB_I && (ADDR_I == ulsi_pkg::RX_BUF_OFS);
    assign wr_thr = wr_acc && !DLAB_I && (ADDR_I == ulsi_pkg::RX_BUF_OFS);
    assign rd_iir = rd_acc && (ADDR_I == ulsi_pkg::IRQ_ID_OFS);
    assign rd_lsr = rd_acc && (ADDR_I == ulsi_pkg::LINE_STATUS_OFS);
    assign wr_lsr = wr_acc && (ADDR_I == ulsi_pkg::LINE_STATUS_OFS);

    // Break: input held low across two character ticks, so the low run
    // always covers more than one whole character time
    assign brk_evt = !st_q.sin_s && CHAR_TICK_I &&
                     (st_q.low_ticks == ulsi_pkg::BRK_TICKS - 2'h1);
    assign push = brk_evt || (RX_CHAR_VALID_I && !st_q.brk_hold);
    assign wdata = brk_evt ? ulsi_pkg::BRK_ENTRY
                           : {1'b0, RX_FE_I, RX_PE_I, RX_DATA_I};
    assign pop = rd_rbr && (cnt != '0);
    assign overrun = push && full && !pop;
    assign fresh = (push && (cnt == (pop ? ulsi_pkg::CNT_W'(1) : '0))) ||
                   (pop && (cnt > ulsi_pkg::CNT_W'(1))) ||
                   (overrun && !FIFO_EN_I);
    // Leaving FIFO mode discards the queued characters
    assign clr = st_q.fifo_en && !FIFO_EN_I;

    ulsi_rx_fifo u_rx_fifo (
        .clk_i     (CLK_I),
        .rst_b_i   (RST_B_I),
        .clr_i     (clr),
        .push_i    (push),
        .pop_i     (pop),
        .cap1_i    (!FIFO_EN_I),
        .wdata_i   (wdata),
        .head_o    (head),
        .count_o   (cnt),
        .full_o    (full),
        .err_any_o (err_any)
    );

    assign data_lvl = FIFO_EN_I ? (cnt >= ulsi_pkg::RX_TRIG_LVL[RX_TRIG_I])
                                : st_q.dr;
    assign line_p  = IRQ_EN_I[ulsi_pkg::IE_LINE] &&
                     (st_q.oe || st_q.pe || st_q.fe || st_q.bi);
    assign data_p  = IRQ_EN_I[ulsi_pkg::IE_DATA] && data_lvl;
    assign tmo_p   = IRQ_EN_I[ulsi_pkg::IE_DATA] && st_q.tmo;
    assign tx_hold_empty_flag_p  = IRQ_EN_I[ulsi_pkg::IE_TX_HOLD_EMPTY_FLAG] && st_q.tx_hold_empty_flag_irq;
    assign modem_p = IRQ_EN_I[ulsi_pkg::IE_MODEM] && MODEM_DELTA_I;

    assign cur_code = line_p  ? ulsi_pkg::IID_LINE  :
                      data_p  ? ulsi_pkg::IID_DATA  :
                      tmo_p   ? ulsi_pkg::IID_TMO   :
                      tx_hold_empty_flag_p  ? ulsi_pkg::IID_TX_HOLD_EMPTY_FLAG  :
                      modem_p ? ulsi_pkg::IID_MODEM :
                                ulsi_pkg::IID_NONE;
    assign frz_live = ((st_q.frz_code == ulsi_pkg::IID_LINE)  && line_p) ||
                      ((st_q.frz_code == ulsi_pkg::IID_DATA)  && data_p) ||
                      ((st_q.frz_code == ulsi_pkg::IID_TMO)   && tmo_p)  ||
                      ((st_q.frz_code == ulsi_pkg::IID_MODEM) && modem_p);
    // A frozen source stays reported until serviced, then the next shows
    assign rep_code = (st_q.frz_v && frz_live) ? st_q.frz_code
                                               : cur_code;
    assign iir_byte = {FIFO_EN_I ? ulsi_pkg::IID_FIFO_MARK : 2'h0,
                       2'h0, rep_code};
    assign tx_all_empty_flag = st_q.tx_hold_empty_flag && TX_SHIFT_EMPTY_I;
    assign lsr_byte = {st_q.fifo_err, tx_all_empty_flag, st_q.tx_hold_empty_flag, st_q.bi,
                       st_q.fe, st_q.pe, st_q.oe, st_q.dr};

    always_comb begin
        st_d = st_q;
        st_d.sin_m = SERIAL_IN_I;
        st_d.sin_s = st_q.sin_m;
        st_d.fifo_en = FIFO_EN_I;
        st_d.head_fresh = fresh;

        if (st_q.sin_s) begin
            st_d.low_ticks = 2'h0;
        end else if (CHAR_TICK_I && st_q.low_ticks < ulsi_pkg::BRK_TICKS) begin
            st_d.low_ticks = st_q.low_ticks + 2'h1;
        end

        // Further characters wait for marking and then a fresh start bit
        if (brk_evt) begin
            st_d.brk_hold = 1'b1;
            st_d.mark_seen = 1'b0;
        end else if (st_q.brk_hold) begin
            if (st_q.sin_s) begin
                st_d.mark_seen = 1'b1;
            end
            if (st_q.mark_seen && RX_START_I) begin
                st_d.brk_hold = 1'b0;
                st_d.mark_seen = 1'b0;
            end
        end

        if (clr) begin
            st_d.dr = 1'b0;
        end else if (push) begin
            st_d.dr = 1'b1;
        end else if ((pop && (cnt == ulsi_pkg::CNT_W'(1))) ||
                     (wr_lsr && !DATA_I[0])) begin
            st_d.dr = 1'b0;
        end

        st_d.oe = overrun || (st_q.oe && !rd_lsr);
        st_d.pe = (st_q.head_fresh && (cnt != '0) && head[ulsi_pkg::E_PE]) ||
                  (st_q.pe && !rd_lsr);
        st_d.fe = (st_q.head_fresh && (cnt != '0) && head[ulsi_pkg::E_FE]) ||
                  (st_q.fe && !rd_lsr);
        st_d.bi = (st_q.head_fresh && (cnt != '0) && head[ulsi_pkg::E_BI]) ||
                  (st_q.bi && !rd_lsr);
        st_d.fifo_err = FIFO_EN_I &&
                        (err_any || (st_q.fifo_err && !rd_lsr));

        if (FIFO_EN_I) begin
            st_d.tx_hold_empty_flag = TX_FIFO_EMPTY_I && !wr_thr;
        end else if (TX_TO_SHIFT_I) begin
            st_d.tx_hold_empty_flag = 1'b1;
        end else if (wr_thr) begin
            st_d.tx_hold_empty_flag = 1'b0;
        end

        if (st_d.tx_hold_empty_flag && !st_q.tx_hold_empty_flag) begin
            st_d.tx_hold_empty_flag_irq = 1'b1;
        end else if (wr_thr ||
                     (rd_iir && (rep_code == ulsi_pkg::IID_TX_HOLD_EMPTY_FLAG))) begin
            st_d.tx_hold_empty_flag_irq = 1'b0;
        end

        // Any FIFO activity restarts the idle count
        if (!FIFO_EN_I || (cnt == '0) || push || pop) begin
            st_d.tmo_cnt = 3'h0;
        end else if (CHAR_TICK_I && st_q.tmo_cnt != ulsi_pkg::TMO_CHARS) begin
            st_d.tmo_cnt = st_q.tmo_cnt + 3'h1;
        end
        st_d.tmo = (st_d.tmo_cnt == ulsi_pkg::TMO_CHARS);

        if (st_q.frz_v && !frz_live) begin
            st_d.frz_v = 1'b0;
        end
        // Holding-empty is serviced by the read itself, so never frozen
        if (rd_iir && !(st_q.frz_v && frz_live) &&
            (cur_code != ulsi_pkg::IID_NONE) &&
            (cur_code != ulsi_pkg::IID_TX_HOLD_EMPTY_FLAG)) begin
            st_d.frz_v = 1'b1;
            st_d.frz_code = cur_code;
        end

        st_d.oe_b = 1'b1;
        if (rd_rbr) begin
            st_d.rdata = head[7:0];
            st_d.oe_b = 1'b0;
        end else if (rd_iir) begin
            st_d.rdata = iir_byte;
            st_d.oe_b = 1'b0;
        end else if (rd_lsr) begin
            st_d.rdata = lsr_byte;
            st_d.oe_b = 1'b0;
        end

        st_d.intr = line_p || data_p || tmo_p || tx_hold_empty_flag_p || modem_p;
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_q <= '0;
            st_q.sin_m <= 1'b1;
            st_q.sin_s <= 1'b1;
            st_q.tx_hold_empty_flag <= 1'b1;
            st_q.oe_b <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign DATA_O = st_q.rdata;
    assign DATA_OE_B_O = st_q.oe_b;
    assign INTR_O = st_q.intr;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    property p_dr_set;
        push && !clr |=> st_q.dr;
    endproperty
    a_dr_set: assert property (p_dr_set)
        else $error("ready flag not set after arrival");

    property p_overrun;
        overrun && !clr |=> st_q.oe [*1] ##0 lsr_byte[1];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged");

    property p_pe_head;
        st_q.head_fresh && (cnt != '0) && head[ulsi_pkg::E_PE]
            |=> st_q.pe;
    endproperty
    a_pe_head: assert property (p_pe_head)
        else $error("parity error at head not shown");

    sequence s_break;
        brk_evt && !RX_START_I;
    endsequence
    sequence s_held;
        st_q.brk_hold [*2];
    endsequence
    property p_break_hold;
        s_break |=> s_held;
    endproperty
    a_break_hold: assert property (p_break_hold)
        else $error("receiver not held after break");

    property p_tx_hold_empty_flag_fifo;
        FIFO_EN_I && TX_FIFO_EMPTY_I && !wr_thr |=> st_q.tx_hold_empty_flag;
    endproperty
    a_tx_hold_empty_flag_fifo: assert property (p_tx_hold_empty_flag_fifo)
        else $error("holding empty not following FIFO");

    property p_tx_all_empty_flag;
        rd_lsr |=> DATA_O[6] == ($past(st_q.tx_hold_empty_flag) && $past(TX_SHIFT_EMPTY_I));
    endproperty
    a_tx_all_empty_flag: assert property (p_tx_all_empty_flag)
        else $error("transmitter empty bit wrong");

    property p_line_first;
        line_p && !st_q.frz_v |-> rep_code == ulsi_pkg::IID_LINE;
    endproperty
    a_line_first: assert property (p_line_first)
        else $error("line status not highest priority");

    property p_iid_bit0;
        rd_iir |=> DATA_O[0] == ($past(rep_code) == ulsi_pkg::IID_NONE);
    endproperty
    a_iid_bit0: assert property (p_iid_bit0)
        else $error("pending bit wrong");

    property p_tmo;
        (st_q.tmo_cnt == 3'h3) && CHAR_TICK_I && FIFO_EN_I &&
            (cnt != '0) && !push && !pop |=> st_q.tmo;
    endproperty
    a_tmo: assert property (p_tmo)
        else $error("timeout missed after four idle characters");

    property p_iid_high;
        rd_iir |=> (DATA_O[5:4] == 2'h0) &&
                   (DATA_O[7:6] == {2{$past(FIFO_EN_I)}});
    endproperty
    a_iid_high: assert property (p_iid_high)
        else $error("identification upper bits wrong");

    property p_intr;
        line_p || data_p || tmo_p || tx_hold_empty_flag_p || modem_p |=> INTR_O;
    endproperty
    a_intr: assert property (p_intr)
        else $error("interrupt output not raised");
endmodule
`default_nettype wire

// *** inc/ulsi_pkg.sv ***
package ulsi_pkg;
    // Register offsets on the three-bit register address
    localparam logic [2:0] RX_BUF_OFS = 3'h0;
    localparam logic [2:0] IRQ_ID_OFS = 3'h2;
    localparam logic [2:0] LINE_STATUS_OFS = 3'h5;

    // Interrupt enable bit positions
    localparam int IE_DATA  = 0;
    localparam int IE_TX_HOLD_EMPTY_FLAG  = 1;
    localparam int IE_LINE  = 2;
    localparam int IE_MODEM = 3;

    // Interrupt identification codes, bits 3 to 0, and the FIFO mark for bits 7 to 6
    localparam logic [3:0] IID_NONE  = 4'h1;
    localparam logic [3:0] IID_LINE  = 4'h6;
    localparam logic [3:0] IID_DATA  = 4'h4;
    localparam logic [3:0] IID_TMO   = 4'hC;
    localparam logic [3:0] IID_TX_HOLD_EMPTY_FLAG  = 4'h2;
    localparam logic [3:0] IID_MODEM = 4'h0;
    localparam logic [1:0] IID_FIFO_MARK = 2'h3;

    // Receive FIFO geometry and entry layout
    localparam int DEPTH   = 16;
    localparam int PTR_W   = 4;
    localparam int CNT_W   = 5;
    localparam int ENTRY_W = 11;
    localparam int ERR_LSB = 8;
    localparam int E_PE    = 8;
    localparam int E_FE    = 9;
    localparam int E_BI    = 10;
    localparam logic [CNT_W-1:0]   DEPTH_CNT = 5'h10;
    localparam logic [ENTRY_W-1:0] BRK_ENTRY = 11'h400;

    // Receive trigger levels indexed by the two trigger select bits
    localparam logic [3:0][CNT_W-1:0] RX_TRIG_LVL =
        {5'h0E, 5'h08, 5'h04, 5'h01};

    // Timing in character times
    localparam logic [2:0] TMO_CHARS = 3'h4;
    localparam logic [1:0] BRK_TICKS = 2'h2;
endpackage

// *** verilog/ulsi_rx_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module ulsi_rx_fifo (
    input  wire logic                         clk_i,
    input  wire logic                         rst_b_i,
    input  wire logic                         clr_i,
    input  wire logic                         push_i,
    input  wire logic                         pop_i,
    input  wire logic                         cap1_i,
    input  wire logic [ulsi_pkg::ENTRY_W-1:0] wdata_i,
    output logic      [ulsi_pkg::ENTRY_W-1:0] head_o,
    output logic      [ulsi_pkg::CNT_W-1:0]   count_o,
    output logic                              full_o,
    output logic                              err_any_o
);
    typedef struct packed {
        logic [ulsi_pkg::DEPTH-1:0][ulsi_pkg::ENTRY_W-1:0] mem;
        logic [ulsi_pkg::PTR_W-1:0]                        rd;
        logic [ulsi_pkg::PTR_W-1:0]                        wr;
        logic [ulsi_pkg::CNT_W-1:0]                        cnt;
    } ulsi_fifo_st_t;

    ulsi_fifo_st_t              st_q;
    ulsi_fifo_st_t              st_d;
    logic [ulsi_pkg::DEPTH-1:0] err_v;
    logic                       do_pop;
    logic                       do_push;
    logic                       ovw;

    assign full_o    = cap1_i ? (st_q.cnt != '0)
                              : (st_q.cnt == ulsi_pkg::DEPTH_CNT);
    assign head_o    = st_q.mem[st_q.rd];
    assign count_o   = st_q.cnt;
    assign err_any_o = |err_v;
    assign do_pop    = pop_i && (st_q.cnt != '0);
    assign do_push   = push_i && (!full_o || do_pop);
    // Character mode keeps one entry: a late arrival replaces it
    assign ovw       = push_i && full_o && cap1_i && !do_pop;

    genvar i;
    generate
        for (i = 0; i < ulsi_pkg::DEPTH; i++) begin : g_err
            logic [ulsi_pkg::PTR_W-1:0] ofs;
            assign ofs = ulsi_pkg::PTR_W'(i) - st_q.rd;
            assign err_v[i] = ({1'b0, ofs} < st_q.cnt) &&
                (|st_q.mem[i][ulsi_pkg::ENTRY_W-1:ulsi_pkg::ERR_LSB]);
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        if (clr_i) begin
            st_d.rd  = '0;
            st_d.wr  = '0;
            st_d.cnt = '0;
        end else begin
            if (ovw) begin
                st_d.mem[st_q.rd] = wdata_i;
            end
            if (do_push) begin
                st_d.mem[st_q.wr] = wdata_i;
                st_d.wr = st_q.wr + 4'h1;
            end
            if (do_pop) begin
                st_d.rd = st_q.rd + 4'h1;
            end
            st_d.cnt = st_q.cnt + ulsi_pkg::CNT_W'(do_push)
                     - ulsi_pkg::CNT_W'(do_pop);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule
`default_nettype wire

// *** dv/ulsi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ulsi_host_model (
    input  wire logic       clk_i,
    output logic            cs_o,
    output logic [2:0]      addr_o,
    output logic            rd_o,
    output logic            wr_o,
    output logic [7:0]      data_o,
    input  wire logic [7:0] rdata_i,
    input  wire logic       oe_b_i
);
    // Released address and data lines carry the inverse of their last value, never a stale copy
    initial begin
        cs_o = 1'b0;
        addr_o = 3'h7;
        rd_o = 1'b0;
        wr_o = 1'b0;
        data_o = 8'hFF;
    end

    // One access: strobe taken at one rising edge; the answer stands only
    // until the next rising edge, so it is read at the falling edge between
    task automatic access(input logic w, input logic [2:0] a,
                          input logic [7:0] d, output logic [7:0] q,
                          output logic oe_b);
        @(negedge clk_i);
        cs_o = 1'b1;
        addr_o = a;
        rd_o = ~w;
        wr_o = w;
        data_o = w ? d : ~data_o;
        @(negedge clk_i);
        q = rdata_i;
        oe_b = oe_b_i;
        cs_o = 1'b0;
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = ~a;
        data_o = ~data_o;
    endtask
endmodule
`default_nettype wire

// *** dv/test_uart_line_status_irq_id.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_uart_line_status_irq_id;
    localparam logic [2:0] RB_A = ulsi_pkg::RX_BUF_OFS;
    localparam logic [2:0] ID_A = ulsi_pkg::IRQ_ID_OFS;
    localparam logic [2:0] LS_A = ulsi_pkg::LINE_STATUS_OFS;

    logic       clk, rst_b, cs, rd, wr, oe_b, intr, fifo_en, modem;
    logic       serial_in, tick, rxv, pe, fe, start, to_shift, txf_e, sh_e;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, rxd, q;
    logic [1:0] trig;
    logic [3:0] ien;
    logic       o;
    int         bad_count, total_checks;

    ulsi_status_irq ulsi_status_irq_inst (
        .CLK_I(clk), .RST_B_I(rst_b), .CS_I(cs), .ADDR_I(addr),
        .RD_I(rd), .WR_I(wr), .DATA_I(wdata), .DATA_O(rdata),
        .DATA_OE_B_O(oe_b), .DLAB_I(1'b0), .FIFO_EN_I(fifo_en),
        .RX_TRIG_I(trig), .IRQ_EN_I(ien), .MODEM_DELTA_I(modem),
        .SERIAL_IN_I(serial_in), .CHAR_TICK_I(tick), .RX_CHAR_VALID_I(rxv),
        .RX_DATA_I(rxd), .RX_PE_I(pe), .RX_FE_I(fe), .RX_START_I(start),
        .TX_TO_SHIFT_I(to_shift), .TX_FIFO_EMPTY_I(txf_e),
        .TX_SHIFT_EMPTY_I(sh_e), .INTR_O(intr)
    );

    ulsi_host_model ulsi_host_model_inst (
        .clk_i(clk), .cs_o(cs), .addr_o(addr), .rd_o(rd), .wr_o(wr),
        .data_o(wdata), .rdata_i(rdata), .oe_b_i(oe_b)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks=%0d errors=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    function automatic logic [7:0] iid(input logic [3:0] c);
        return {{2{fifo_en}}, 2'h0, c};
    endfunction

    task automatic rreg(input logic [2:0] a, input logic [7:0] exp);
        ulsi_host_model_inst.access(1'b0, a, 8'h00, q, o);
        chk1(o, 1'b0);
        chk8(q, exp);
    endtask

    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        ulsi_host_model_inst.access(1'b1, a, d, q, o);
    endtask

    // Flags of the head show two edges after the strobe, so wait past that
    task automatic rx_char(input logic [7:0] d, input logic p, input logic f);
        @(negedge clk);
        rxv = 1'b1;
        rxd = d;
        pe = p;
        fe = f;
        @(negedge clk);
        rxv = 1'b0;
        rxd = ~d;
        repeat (2) @(negedge clk);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clk);
            tick = 1'b1;
            @(negedge clk);
            tick = 1'b0;
        end
        repeat (2) @(negedge clk);
    endtask

    initial begin
        #50000;
        bad_count++;
        complete_run();
    end

    initial begin
        {rst_b, fifo_en, modem, tick, rxv, pe, fe, start, to_shift} = '0;
        {serial_in, txf_e, sh_e} = 3'h7;
        rxd = 8'h00;
        trig = 2'h1;
        ien = 4'h0;
        bad_count = 0;
        total_checks = 0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        rreg(LS_A, 8'h60);
        rreg(ID_A, iid(ulsi_pkg::IID_NONE));
        ulsi_host_model_inst.access(1'b0, 3'h3, 8'h00, q, o);
        chk1(o, 1'b1);
        ien = 4'h5;
        rx_char(8'hA5, 1'b1, 1'b0);
        chk1(intr, 1'b1);
        rreg(ID_A, iid(ulsi_pkg::IID_LINE));
        rreg(LS_A, 8'h65);
        rreg(ID_A, iid(ulsi_pkg::IID_DATA));
        rreg(RB_A, 8'hA5);
        rreg(ID_A, iid(ulsi_pkg::IID_NONE));
        chk1(intr, 1'b0);
        rx_char(8'h3C, 1'b0, 1'b1);
        wreg(LS_A, 8'h00);
        rreg(LS_A, 8'h68);
        rreg(LS_A, 8'h60);
        rx_char(8'h11, 1'b0, 1'b0);
        rx_char(8'h22, 1'b0, 1'b0);
        rreg(LS_A, 8'h63);
        rreg(LS_A, 8'h61);
        rreg(RB_A, 8'h22);
        ien = 4'h0;
        rx_char(8'h33, 1'b1, 1'b0);
        chk1(intr, 1'b0);
        rreg(LS_A, 8'h65);
        rreg(RB_A, 8'h33);
        ien = 4'hC;
        modem = 1'b1;
        repeat (2) @(negedge clk);
        rreg(ID_A, iid(ulsi_pkg::IID_MODEM));
        rx_char(8'h44, 1'b0, 1'b1);
        rreg(ID_A, iid(ulsi_pkg::IID_MODEM));
        modem = 1'b0;
        repeat (2) @(negedge clk);
        rreg(ID_A, iid(ulsi_pkg::IID_LINE));
        rreg(LS_A, 8'h69);
        rreg(ID_A, iid(ulsi_pkg::IID_NONE));
        rreg(RB_A, 8'h44);
        ien = 4'h2;
        sh_e = 1'b0;
        wreg(RB_A, 8'h77);
        rreg(LS_A, 8'h00);
        @(negedge clk);
        to_shift = 1'b1;
        @(negedge clk);
        to_shift = 1'b0;
        repeat (2) @(negedge clk);
        chk1(intr, 1'b1);
        rreg(ID_A, iid(ulsi_pkg::IID_TX_HOLD_EMPTY_FLAG));
        rreg(ID_A, iid(ulsi_pkg::IID_NONE));
        rreg(LS_A, 8'h20);
        sh_e = 1'b1;
        rreg(LS_A, 8'h60);
        // Holding write must also retire a pending holding-empty request
        wreg(RB_A, 8'h78);
        @(negedge clk);
        to_shift = 1'b1;
        @(negedge clk);
        to_shift = 1'b0;
        repeat (2) @(negedge clk);
        chk1(intr, 1'b1);
        wreg(RB_A, 8'h79);
        @(negedge clk);
        chk1(intr, 1'b0);
        ien = 4'h1;
        fifo_en = 1'b1;
        repeat (2) @(negedge clk);
        rreg(ID_A, iid(ulsi_pkg::IID_NONE));
        txf_e = 1'b0;
        rreg(LS_A, 8'h00);
        txf_e = 1'b1;
        rx_char(8'h55, 1'b0, 1'b0);
        rx_char(8'h66, 1'b1, 1'b0);
        rreg(LS_A, 8'hE1);
        rreg(RB_A, 8'h55);
        rreg(LS_A, 8'hE5);
        rreg(RB_A, 8'h66);
        // Error summary sticks until a status read finds the queue clean
        rreg(LS_A, 8'hE0);
        rreg(LS_A, 8'h60);
        rx_char(8'h77, 1'b0, 1'b0);
        ticks(3);
        rreg(ID_A, iid(ulsi_pkg::IID_NONE));
        ticks(1);
        chk1(intr, 1'b1);
        rreg(ID_A, iid(ulsi_pkg::IID_TMO));
        rreg(RB_A, 8'h77);
        rreg(ID_A, iid(ulsi_pkg::IID_NONE));
        serial_in = 1'b0;
        repeat (3) @(negedge clk);
        ticks(3);
        rx_char(8'h88, 1'b0, 1'b0);
        rreg(LS_A, 8'hF1);
        rreg(RB_A, 8'h00);
        rreg(LS_A, 8'hE0);
        serial_in = 1'b1;
        repeat (3) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        rx_char(8'h99, 1'b0, 1'b0);
        rreg(LS_A, 8'h61);
        rreg(RB_A, 8'h99);
        trig = 2'h0;
        rx_char(8'h5A, 1'b0, 1'b0);
        rreg(ID_A, iid(ulsi_pkg::IID_DATA));
        rreg(RB_A, 8'h5A);
        complete_run();
    end
endmodule
`default_nettype wire
